/* File: hdl/adc_output_port.sv */
`timescale 1ns/1ns
`default_nettype none

module adc_output_port
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire adc_port_pkg::sample_t sampleCode,
    input wire logic outEnableInB,
    input wire logic outEnableDriven,
    input wire logic powerDownCtrl,
    input wire logic rangeSelect,
    input wire logic rangeSelectDriven,
    input wire logic referenceSourceSelect,
    input wire logic referenceSourceDriven,
    input wire logic sinkReady,
    output logic [9:0] dataPinOut,
    output logic [9:0] dataPinOeB,
    output logic wordValid,
    output logic sampleTaken,
    output logic rangeTwoVolt,
    output logic refExternal,
    output logic powerDownState
);

    // ------------------------------------------------------------
    // Types and state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0][1:0] syncPin;
        // Stages before the buffer; buffer write and pin flop make up the rest
        adc_port_pkg::sample_t [adc_port_pkg::PIPE_LATENCY-2:0] pipe;
        logic [adc_port_pkg::PIPE_LATENCY-2:0] pipeValid;
        adc_port_pkg::pwr_state_t pwr;
        logic [2:0] fill;
        adc_port_pkg::config_t cfg;
        adc_port_pkg::sample_t pinOut;
        logic [9:0] pinOeB;
        logic wordValid;
        logic sampleTaken;
    } port_state_t;

    port_state_t s_q;
    port_state_t s_d;
    logic oeLevel;
    logic rangeLevel;
    logic refLevel;
    logic bufValid;
    adc_port_pkg::sample_t bufData;
    logic bufInReady;
    logic bufTake;
    logic oeSyncB;

    // ------------------------------------------------------------
    // Pull resistors resolved before synchronising
    // ------------------------------------------------------------
    assign oeLevel = outEnableDriven ? outEnableInB : 1'b0;
    assign rangeLevel = rangeSelectDriven ? rangeSelect : 1'b1;
    assign refLevel = referenceSourceDriven ? referenceSourceSelect : 1'b1;
    assign oeSyncB = s_q.syncPin[0][1];

    // Output word buffer absorbs a stalled receiver
    skid_buffer u_buf
    (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .inValid(s_q.pipeValid[adc_port_pkg::PIPE_LATENCY-2]),
        .inData(s_q.pipe[adc_port_pkg::PIPE_LATENCY-2]),
        .inReady(bufInReady),
        .outValid(bufValid),
        .outData(bufData),
        .outReady(bufTake)
    );

    // Drain while receiver ready and pins enabled
    assign bufTake = sinkReady && !oeSyncB;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        // Two-stage synchronisers for pins
        s_d.syncPin[0] = {s_q.syncPin[0][0], oeLevel};
        s_d.syncPin[1] = {s_q.syncPin[1][0], rangeLevel};
        s_d.syncPin[2] = {s_q.syncPin[2][0], refLevel};
        s_d.cfg.powerDown = (s_q.pwr == adc_port_pkg::PWR_OFF);
        s_d.cfg.rangeTwoVolt = s_q.syncPin[1][1];
        s_d.cfg.refExternal = s_q.syncPin[2][1];
        s_d.sampleTaken = 1'b0;

        // Power control
        case (s_q.pwr)
            adc_port_pkg::PWR_OFF:
            begin
                if (!powerDownCtrl)
                begin
                    s_d.pwr = adc_port_pkg::PWR_FILL;
                    s_d.fill = 3'h0;
                end
            end
            adc_port_pkg::PWR_FILL:
            begin
                if (powerDownCtrl)
                begin
                    s_d.pwr = adc_port_pkg::PWR_OFF;
                end
                else if (bufInReady && s_q.fill == adc_port_pkg::PIPE_LAST)
                begin
                    s_d.pwr = adc_port_pkg::PWR_RUN;
                end
                else if (bufInReady)
                begin
                    s_d.fill = s_q.fill + 3'h1;
                end
            end
            adc_port_pkg::PWR_RUN:
            begin
                if (powerDownCtrl)
                begin
                    s_d.pwr = adc_port_pkg::PWR_OFF;
                end
            end
            default:
            begin
                s_d.pwr = adc_port_pkg::PWR_OFF;
            end
        endcase

        // Pipeline stages advance once per clock, stall on full buffer
        if (s_q.pwr == adc_port_pkg::PWR_OFF || powerDownCtrl)
        begin
            s_d.pipeValid = '0;
        end
        else if (bufInReady)
        begin
            s_d.pipe[0] = sampleCode;
            s_d.pipeValid[0] = 1'b1;
            s_d.sampleTaken = 1'b1;
            for (int i = 1; i < adc_port_pkg::PIPE_LATENCY - 1; i++)
            begin
                s_d.pipe[i] = s_q.pipe[i-1];
                s_d.pipeValid[i] = s_q.pipeValid[i-1];
            end
        end

        // Pin drive
        if (bufTake && bufValid)
        begin
            s_d.pinOut = adc_port_pkg::pin_order(bufData);
        end
        s_d.wordValid = bufTake && bufValid;
        s_d.pinOeB = {10{oeSyncB}};
    end

    // Register
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            s_q <= '0;
            // Synchronisers start high (pins disabled, 2 V span, external reference), no false span change
            s_q.syncPin <= '1;
            s_q.pwr <= adc_port_pkg::PWR_OFF;
            s_q.pinOeB <= 10'h3ff;
            s_q.cfg.rangeTwoVolt <= adc_port_pkg::SPAN_2V;
            s_q.cfg.refExternal <= adc_port_pkg::REF_EXTERNAL;
            s_q.cfg.powerDown <= 1'b1;
        end
        else if (clkEn)
        begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs straight from flops
    // ------------------------------------------------------------
    assign dataPinOut = s_q.pinOut;
    assign dataPinOeB = s_q.pinOeB;
    assign wordValid = s_q.wordValid;
    assign sampleTaken = s_q.sampleTaken;
    assign rangeTwoVolt = s_q.cfg.rangeTwoVolt;
    assign refExternal = s_q.cfg.refExternal;
    assign powerDownState = s_q.cfg.powerDown;

endmodule : adc_output_port

`default_nettype wire

/* File: hdl/adc_port_pkg.sv */
package adc_port_pkg;

    // ------------------------------------------------------------
    // Sizes and counts
    // ------------------------------------------------------------
    localparam int SAMPLE_WIDTH = 10;
    localparam int PIPE_LATENCY = 5;
    localparam logic [2:0] PIPE_LAST = 3'h4;
    localparam logic [2:0] FILL_COUNT = 3'h5;
    localparam logic [9:0] CODE_RESET = 10'h000;
    localparam logic [9:0] CODE_MAX = 10'h3ff;

    // Span and reference choices
    localparam logic SPAN_2V = 1'b1;
    localparam logic SPAN_1V = 1'b0;
    localparam logic REF_EXTERNAL = 1'b1;
    localparam logic REF_INTERNAL = 1'b0;

    typedef logic [SAMPLE_WIDTH-1:0] sample_t;

    // Static configuration seen by the converter
    typedef struct packed {
        logic powerDown;
        logic rangeTwoVolt;
        logic refExternal;
    } config_t;

    // One word with its valid flag
    typedef struct packed {
        logic valid;
        sample_t data;
    } word_t;

    // Power state
    typedef enum logic [1:0] {
        PWR_OFF = 2'b00,
        PWR_FILL = 2'b01,
        PWR_RUN = 2'b11
    } pwr_state_t;

    // Bit reversal: output pin one carries the MSB
    function automatic sample_t pin_order(input sample_t code);
        sample_t r;
        r = '0;
        for (int i = 0; i < SAMPLE_WIDTH; i++)
        begin
            r[i] = code[SAMPLE_WIDTH-1-i];
        end
        return r;
    endfunction : pin_order

endpackage : adc_port_pkg

/* File: hdl/skid_buffer.sv */
`timescale 1ns/1ns
`default_nettype none

module skid_buffer
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic inValid,
    input wire adc_port_pkg::sample_t inData,
    output logic inReady,
    output logic outValid,
    output adc_port_pkg::sample_t outData,
    input wire logic outReady
);

    // ------------------------------------------------------------
    // Two-entry store
    // ------------------------------------------------------------
    typedef struct packed {
        adc_port_pkg::sample_t [1:0] mem;
        logic [1:0] count;
        logic rd;
        logic wr;
    } skid_state_t;

    skid_state_t s_q;
    skid_state_t s_d;
    logic doWrite;
    logic doRead;

    assign inReady = (s_q.count != 2'h2);
    assign outValid = (s_q.count != 2'h0);
    assign outData = s_q.mem[s_q.rd];
    assign doWrite = inValid && inReady;
    assign doRead = outValid && outReady;

    // Next state
    always_comb
    begin
        s_d = s_q;
        if (doWrite)
        begin
            s_d.mem[s_q.wr] = inData;
            s_d.wr = ~s_q.wr;
        end
        if (doRead)
        begin
            s_d.rd = ~s_q.rd;
        end
        s_d.count = s_q.count + {1'b0, doWrite} - {1'b0, doRead};
    end

    // Register
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            s_q <= '0;
        end
        else if (clkEn)
        begin
            s_q <= s_d;
        end
    end

endmodule : skid_buffer

`default_nettype wire

/* File: verif/adc_output_port_chk.sv */
`timescale 1ns/1ns
`default_nettype none

module adc_output_port_chk
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire adc_port_pkg::sample_t sampleCode,
    input wire logic outEnableInB,
    input wire logic outEnableDriven,
    input wire logic powerDownCtrl,
    input wire logic rangeSelect,
    input wire logic rangeSelectDriven,
    input wire logic referenceSourceSelect,
    input wire logic referenceSourceDriven,
    input wire logic sinkReady,
    input wire logic [9:0] dataPinOeB,
    input wire logic [9:0] dataPinOut,
    input wire logic wordValid,
    input wire logic sampleTaken,
    input wire logic rangeTwoVolt,
    input wire logic refExternal,
    input wire logic powerDownState
);
    // ----------
    // Helpers
    // ----------
    logic [3:0] upCnt;
    logic [9:0] revCode;
    logic flow;
    // Pin order and free-flow condition
    assign revCode = {<<{sampleCode}};
    assign flow = sinkReady & ~powerDownCtrl & (dataPinOeB == 10'h000);
    // Cycles since reset release
    always_ff @(posedge clk_sys)
        upCnt <= !rst_b ? 4'h0 : upCnt + {3'h0, upCnt != 4'hf};

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    property p_oe; upCnt > 4'h3 |-> dataPinOeB == {10{$past(outEnableDriven & outEnableInB, 3)}};
    endproperty
    a_oe: assert property (p_oe) else $error("pin enable wrong");
    property p_range; upCnt > 4'h3 |-> rangeTwoVolt == $past(rangeSelect | ~rangeSelectDriven, 3);
    endproperty
    a_range: assert property (p_range) else $error("span wrong");
    property p_ref;
        upCnt > 4'h3 |-> refExternal == $past(referenceSourceSelect | ~referenceSourceDriven, 3);
    endproperty
    a_ref: assert property (p_ref) else $error("reference wrong");
    property p_pdState; powerDownCtrl |-> ##2 powerDownState; endproperty
    a_pdState: assert property (p_pdState) else $error("no power-down");
    property p_pdWake; !powerDownCtrl [*3] |-> !powerDownState; endproperty
    a_pdWake: assert property (p_pdWake) else $error("stuck in power-down");
    property p_pdNoSample; powerDownCtrl |=> !sampleTaken; endproperty
    a_pdNoSample: assert property (p_pdNoSample) else $error("sampled in power-down");
    property p_latency;
        sampleTaken ##0 flow [*6] |-> wordValid && dataPinOut == $past(revCode, 6);
    endproperty
    a_latency: assert property (p_latency) else $error("word late or wrong");
    property p_perClk; flow [*8] |-> wordValid == $past(sampleTaken, 5); endproperty
    a_perClk: assert property (p_perClk) else $error("word rate wrong");

    c_word: cover property (wordValid);
    c_pd: cover property (powerDownState);
    c_float: cover property (dataPinOeB == 10'h3ff);
endmodule : adc_output_port_chk

bind adc_output_port adc_output_port_chk i_chk (.clk_sys, .rst_b, .sampleCode, .outEnableInB,
    .outEnableDriven, .powerDownCtrl, .rangeSelect, .rangeSelectDriven, .referenceSourceSelect,
    .referenceSourceDriven, .sinkReady, .dataPinOeB, .dataPinOut, .wordValid, .sampleTaken,
    .rangeTwoVolt, .refExternal, .powerDownState);

`default_nettype wire

/* File: verif/capture_model.sv */
`timescale 1ns/1ns
`default_nettype none

module capture_model
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic slowMode,
    input wire logic [9:0] dataPinOut,
    input wire logic [9:0] dataPinOeB,
    input wire logic wordValid,
    output logic sinkReady,
    output logic [9:0] seenWord,
    output logic [7:0] wordCount
);
    // ----------
    // Pins and pacing
    // ----------
    wire [9:0] pinBus;
    logic [1:0] paceCnt;
    // Released pins float
    for (genvar i = 0; i < 10; i++)
    begin : g_pin
        assign pinBus[i] = dataPinOeB[i] ? 1'bz : dataPinOut[i];
    end
    // Pin bit one is the top bit of the code
    assign seenWord = {<<{pinBus}};
    assign sinkReady = !slowMode || paceCnt == 2'h0;
    // Slow pace takes one word in four; words counted so warm-up ones can be dropped
    always_ff @(posedge clk_sys)
    begin
        paceCnt <= !rst_b ? 2'h0 : paceCnt + 2'h1;
        wordCount <= !rst_b ? 8'h00 : wordCount + {7'h0, wordValid};
    end
endmodule : capture_model

`default_nettype wire

/* File: verif/tb_pipelined_adc_output_port.sv */
`timescale 1ns/1ns
`default_nettype none

module tb_pipelined_adc_output_port;
    // ----------
    // Stimulus and observation
    // ----------
    logic clk_sys = 1'b0, rst_b = 1'b0, oeB = 1'b0, oeDrv = 1'b1, pd = 1'b1, slow = 1'b0;
    logic range_select = 1'b1, rselDrv = 1'b1, refSel = 1'b1, refDrv = 1'b1;
    adc_port_pkg::sample_t code = 10'h000;
    logic [9:0] pinOut, pinOeB, seen;
    logic wordValid, sampleTaken, rangeTwoVolt, refExternal, powerDownState, sinkReady;
    int numErrors = 0, nTests = 0;

    adc_output_port i_dut
    (
        .clk_sys(clk_sys), .rst_b(rst_b), .clkEn(1'b1), .sampleCode(code),
        .outEnableInB(oeB), .outEnableDriven(oeDrv), .powerDownCtrl(pd), .rangeSelect(range_select),
        .rangeSelectDriven(rselDrv), .referenceSourceSelect(refSel),
        .referenceSourceDriven(refDrv), .sinkReady(sinkReady), .dataPinOut(pinOut),
        .dataPinOeB(pinOeB), .wordValid(wordValid), .sampleTaken(sampleTaken),
        .rangeTwoVolt(rangeTwoVolt), .refExternal(refExternal), .powerDownState(powerDownState)
    );
    capture_model i_cap
    (
        .clk_sys(clk_sys), .rst_b(rst_b), .slowMode(slow), .dataPinOut(pinOut),
        .dataPinOeB(pinOeB), .wordValid(wordValid), .sinkReady(sinkReady), .seenWord(seen),
        .wordCount()
    );

    // Clock
    initial forever #10 clk_sys = ~clk_sys;

    task automatic check(input string what, input logic [9:0] got, input logic [9:0] exp);
        nTests++;
        if (got !== exp)
        begin
            numErrors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : tick

    // Every level of range and reference, then both pins left open
    task automatic t_config;
        for (int i = 0; i < 5; i++)
        begin
            {refSel, range_select} = i[1:0];
            rselDrv = !i[2];
            refDrv = !i[2];
            tick(4);
            check("span", {9'h0, rangeTwoVolt}, {9'h0, range_select | !rselDrv});
            check("reference", {9'h0, refExternal}, {9'h0, refSel | !refDrv});
        end
    endtask : t_config

    // Power-down entry and exit
    task automatic t_power;
        pd = 1'b1;
        tick(3);
        check("pdState", {9'h0, powerDownState}, 10'h001);
        check("taken", {9'h0, sampleTaken}, 10'h000);
        pd = 1'b0;
        tick(3);
        check("pdState", {9'h0, powerDownState}, 10'h000);
        tick(8);
    endtask : t_power

    // Back-to-back words with boundary codes
    task automatic t_stream;
        adc_port_pkg::sample_t hist [40];
        for (int k = 0; k < 40; k++)
        begin
            if (k >= 6)
            begin
                check("valid", {9'h0, wordValid}, 10'h001);
                check("word", seen, hist[k-6]);
            end
            hist[k] = (k % 3 == 0) ? 10'h3ff : (k % 3 == 1) ? 10'h000 : 10'(k * 37);
            code = hist[k];
            tick(1);
        end
    endtask : t_stream

    // Slow sink: sampling refused, no word lost, order kept
    task automatic t_stall;
        adc_port_pkg::sample_t nextExp;
        int refused;
        nextExp = 10'h200;
        refused = 0;
        code = 10'h200;
        slow = 1'b1;
        for (int k = 0; k < 80; k++)
        begin
            tick(1);
            if (k == 50)
                slow = 1'b0;
            if (wordValid && seen === nextExp)
                nextExp++;
            if (sampleTaken)
                code++;
            else
                refused++;
        end
        check("refused", {9'h0, refused > 0}, 10'h001);
        check("inFlight", code - nextExp, 10'h005);
    endtask : t_stall

    // Pins float while disabled, driven by default when open
    task automatic t_oe;
        oeB = 1'b1;
        tick(8);
        check("oe", pinOeB, 10'h3ff);
        check("float", seen, 10'hzzz);
        check("held", {9'h0, wordValid}, 10'h000);
        oeDrv = 1'b0;
        tick(4);
        check("oe", pinOeB, 10'h000);
    endtask : t_oe

    task automatic finish_test;
        $display("checks %0d errors %0d", nTests, numErrors);
        if (numErrors == 0 && nTests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    // Main sequence
    initial
    begin
        tick(10);
        rst_b = 1'b1;
        t_config;
        t_power;
        t_stream;
        t_stall;
        t_oe;
        finish_test;
    end

    // Watchdog
    initial
    begin
        #20000;
        numErrors++;
        finish_test;
    end
endmodule : tb_pipelined_adc_output_port

`default_nettype wire
